// ===== verilog/tsfr_pkg.sv
`default_nettype none
package tsfr_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_FILL_POS  = 8'h04;
   localparam logic [7:0] ADDR_READ_POS  = 8'h05;
   localparam logic [7:0] ADDR_LOST      = 8'h06;
   localparam logic [7:0] ADDR_TALLY     = 8'h07;
   localparam logic [7:0] ADDR_ITEM_BYTE = 8'h08;
   localparam logic [7:0] ADDR_SEQ_1_2   = 8'h20;
   localparam logic [7:0] ADDR_SEQ_3_4   = 8'h21;
   localparam logic [7:0] ADDR_SEQ_5_6   = 8'h22;
   // Geometry and field positions
   localparam int         DEPTH          = 128;
   localparam logic [7:0] DEPTH_COUNT    = 8'h80;
   localparam int         TAG_MSB        = 23;
   localparam int         TAG_LSB        = 19;
   localparam int         VAL_MSB        = 18;
   localparam int         NUM_SLOTS      = 6;
   localparam logic [1:0] LAST_BYTE      = 2'h2;
   // Reset values and limits
   localparam logic [7:0] TALLY_RST      = 8'h00;
   localparam logic [6:0] POS_RST        = 7'h00;
   localparam logic [6:0] LOST_RST       = 7'h00;
   localparam logic [6:0] LOST_MAX       = 7'h7F;
   localparam logic [7:0] SEQ_RST        = 8'h00;
   // Tags and slot codes
   localparam logic [4:0] TAG_INVALID    = 5'h1E;
   localparam logic [4:0] TAG_CH2_OFS    = 5'h06;
   localparam logic [3:0] SLOT_NONE      = 4'h0;
   localparam logic [3:0] SLOT_EMIT1     = 4'h1;
   localparam logic [3:0] SLOT_EMIT12    = 4'h4;
   localparam logic [3:0] SLOT_AMBIENT   = 4'h9;
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_REQ   = 2'b01,
      SEQ_PUSH2 = 2'b11
   } tsfr_seq_t;
endpackage
`default_nettype wire

// ===== verilog/tsfr_item_store.sv
`timescale 1ns/1ps
`default_nettype none
module tsfr_item_store
   import tsfr_pkg::*;
(
   // Clock
   input  wire logic        clk,
   // Write side
   input  wire logic        wr_en,
   input  wire logic [6:0]  wr_addr,
   input  wire logic [23:0] wr_data,
   // Read side
   input  wire logic [6:0]  rd_addr,
   output logic      [23:0] rd_data
);
   // Storage has no reset: the tally decides what is valid
   logic [23:0] mem [0:DEPTH-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// ===== verilog/tsfr_slot_seq.sv
`timescale 1ns/1ps
`default_nettype none
module tsfr_slot_seq
   import tsfr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Period start and slot settings
   input  wire logic        start,
   input  wire logic [23:0] slot_codes,
   // Conversion handshake
   output logic             conv_req,
   output logic [2:0]       slot_num,
   output logic [3:0]       slot_code,
   output logic             emit1,
   output logic             emit2,
   input  wire logic        conv_done,
   input  wire logic [18:0] ch1_value,
   input  wire logic [18:0] ch2_value,
   // Items towards the store, and the active slot count
   output logic             push_valid,
   output logic [23:0]      push_item,
   output logic [2:0]       active_count
);
   tsfr_seq_t   state_q;
   logic [2:0]  idx_q;
   logic [18:0] ch2_q;
   logic [NUM_SLOTS-1:0] nz;
   logic [4:0]  tag_k;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_nz
         assign nz[gi] = (slot_codes[gi*4 +: 4] != SLOT_NONE);
      end
   endgenerate

   // Active slots are the leading non-zero ones; a gap ends the period
   always_comb begin
      logic run;
      run = 1'b1;
      active_count = 3'h0;
      for (int i = 0; i < NUM_SLOTS; i++) begin
         run = run & nz[i];
         if (run) begin
            active_count = active_count + 3'h1;
         end
      end
   end

   assign tag_k     = {2'b00, idx_q} + 5'h01;
   assign conv_req  = (state_q == SEQ_REQ);
   assign slot_num  = idx_q;
   assign slot_code = slot_codes[idx_q*4 +: 4];
   // Combined code fires both emitters; otherwise only SLOT_EMIT1 fires one, and emitter two has no code of its own
   assign emit1     = conv_req && (slot_code == SLOT_EMIT1 || slot_code == SLOT_EMIT12);
   assign emit2     = conv_req && (slot_code == SLOT_EMIT12);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= SEQ_IDLE;
         idx_q   <= 3'h0;
      end else begin
         case (state_q)
            SEQ_IDLE: begin
               if (start && active_count != 3'h0) begin
                  state_q <= SEQ_REQ;
                  idx_q   <= 3'h0;
               end
            end
            SEQ_REQ: begin
               if (conv_done) begin
                  state_q <= SEQ_PUSH2;
               end
            end
            SEQ_PUSH2: begin
               // Slot order within the period, repeated each period
               if (idx_q + 3'h1 < active_count) begin
                  state_q <= SEQ_REQ;
                  idx_q   <= idx_q + 3'h1;
               end else begin
                  state_q <= SEQ_IDLE;
               end
            end
            default: begin
               state_q <= SEQ_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         push_valid <= 1'b0;
         push_item  <= 24'h000000;
         ch2_q      <= 19'h00000;
      end else begin
         push_valid <= 1'b0;
         if (state_q == SEQ_REQ && conv_done) begin
            // First channel goes first; tag above a 19-bit value
            push_valid <= 1'b1;
            push_item  <= {tag_k, ch1_value};
            ch2_q      <= ch2_value;
         end else if (state_q == SEQ_PUSH2) begin
            push_valid <= 1'b1;
            push_item  <= {tag_k + TAG_CH2_OFS, ch2_q};
         end
      end
   end

   property p_ch2_follows;
      @(posedge clk) disable iff (rst)
      (state_q == SEQ_REQ && conv_done) |=> push_valid ##1
         (push_valid && push_item[TAG_MSB:TAG_LSB] == $past(push_item[TAG_MSB:TAG_LSB]) + 5'h06);
   endproperty
   a_ch2_follows: assert property (p_ch2_follows) else $error("second channel item misplaced");

   property p_emit_both;
      @(posedge clk) disable iff (rst)
      (conv_req && slot_code == SLOT_EMIT12) |-> (emit1 && emit2);
   endproperty
   a_emit_both: assert property (p_emit_both) else $error("combined slot did not fire both");

   c_full_period: cover property (@(posedge clk) disable iff (rst)
      (state_q == SEQ_PUSH2 && idx_q == 3'h5));
endmodule
`default_nettype wire

// ===== verilog/tsfr_readout.sv
`timescale 1ns/1ps
`default_nettype none
module tsfr_readout
   import tsfr_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   // Register access from the serial interface
   input  wire logic        REG_RD,
   input  wire logic        REG_WR,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        BURST_END,
   output logic      [7:0]  REG_RDATA,
   output logic             REG_RVALID,
   // Conversion side
   input  wire logic        SAMPLE_START,
   output logic             CONV_REQ,
   output logic      [2:0]  CONV_SLOT,
   output logic      [3:0]  CONV_CODE,
   output logic             EMIT_ONE,
   output logic             EMIT_TWO,
   input  wire logic        CONV_DONE,
   input  wire logic [18:0] CONV_CH1,
   input  wire logic [18:0] CONV_CH2,
   // Status
   output logic      [2:0]  ACTIVE_SLOTS
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]  tally_q;
   logic [6:0]  fill_pos_q;
   logic [6:0]  readout_pos_q;
   logic [6:0]  lost_q;
   logic [7:0]  seq12_q;
   logic [7:0]  seq34_q;
   logic [7:0]  seq56_q;
   logic [1:0]  byte_idx_q;
   logic        burst_ok_q;
   logic [23:0] item_q;
   logic [23:0] head_item;
   logic        push_valid;
   logic [23:0] push_item;
   logic        empty;
   logic        full;
   logic        data_rd;
   logic        pop;
   logic        push_ok;
   logic        drop;
   logic [7:0]  rdata_d;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Submodules
   tsfr_item_store u_store (
      .clk     (CLK_SYS),
      .wr_en   (push_ok),
      .wr_addr (fill_pos_q),
      .wr_data (push_item),
      .rd_addr (readout_pos_q),
      .rd_data (head_item)
   );

   tsfr_slot_seq u_seq (
      .clk          (CLK_SYS),
      .rst          (SYS_RST),
      .start        (SAMPLE_START),
      .slot_codes   ({seq56_q, seq34_q, seq12_q}),
      .conv_req     (CONV_REQ),
      .slot_num     (CONV_SLOT),
      .slot_code    (CONV_CODE),
      .emit1        (EMIT_ONE),
      .emit2        (EMIT_TWO),
      .conv_done    (CONV_DONE),
      .ch1_value    (CONV_CH1),
      .ch2_value    (CONV_CH2),
      .push_valid   (push_valid),
      .push_item    (push_item),
      .active_count (ACTIVE_SLOTS)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Push and pop decisions
   assign empty   = (tally_q == TALLY_RST);
   assign full    = (tally_q == DEPTH_COUNT);
   assign data_rd = REG_RD && (REG_ADDR == ADDR_ITEM_BYTE);
   // Only a whole three-byte burst on real data releases an item
   assign pop     = data_rd && (byte_idx_q == LAST_BYTE) && burst_ok_q;
   // A pop in the same cycle frees the slot the push needs
   assign push_ok = push_valid && (!full || pop);
   // Newest item is the one lost when the store is full
   assign drop    = push_valid && !push_ok;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Stored item tally
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         tally_q <= TALLY_RST;
      end else if (push_ok && !pop) begin
         tally_q <= tally_q + 8'h01;
      end else if (pop && !push_ok) begin
         tally_q <= tally_q - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Positions
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         fill_pos_q <= POS_RST;
      end else if (push_ok) begin
         fill_pos_q <= fill_pos_q + 7'h01;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         readout_pos_q <= POS_RST;
      end else if (pop) begin
         // 7-bit counter wraps from 0x7F to 0 by width
         readout_pos_q <= readout_pos_q + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Lost item tally
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         lost_q <= LOST_RST;
      end else if (drop) begin
         // Drop and pop never coincide since a pop lets the push in
         if (lost_q != LOST_MAX) begin
            lost_q <= lost_q + 7'h01;
         end
      end else if (pop) begin
         lost_q <= LOST_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Sequence control registers, two slot codes each, low nibble first
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         seq12_q <= SEQ_RST;
         seq34_q <= SEQ_RST;
         seq56_q <= SEQ_RST;
      end else if (REG_WR) begin
         // Writes to the tallies, positions and item port fall through
         if (REG_ADDR == ADDR_SEQ_1_2) begin
            seq12_q <= REG_WDATA;
         end else if (REG_ADDR == ADDR_SEQ_3_4) begin
            seq34_q <= REG_WDATA;
         end else if (REG_ADDR == ADDR_SEQ_5_6) begin
            seq56_q <= REG_WDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Burst tracking
   // The head item is captured on the first byte so a push mid-burst cannot tear it
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         byte_idx_q <= 2'h0;
         burst_ok_q <= 1'b0;
         item_q     <= 24'h000000;
      end else if (data_rd) begin
         if (byte_idx_q == 2'h0) begin
            burst_ok_q <= !empty;
            // Empty store answers with the invalid tag
            item_q     <= empty ? {TAG_INVALID, 19'h00000} : head_item;
            byte_idx_q <= 2'h1;
         end else if (byte_idx_q == LAST_BYTE) begin
            byte_idx_q <= 2'h0;
         end else begin
            byte_idx_q <= byte_idx_q + 2'h1;
         end
      end else if (BURST_END) begin
         // A split access abandons the item without consuming it
         byte_idx_q <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read data
   always_comb begin
      rdata_d = 8'h00;
      if (REG_ADDR == ADDR_FILL_POS) begin
         rdata_d = {1'b0, fill_pos_q};
      end else if (REG_ADDR == ADDR_READ_POS) begin
         rdata_d = {1'b0, readout_pos_q};
      end else if (REG_ADDR == ADDR_LOST) begin
         rdata_d = {1'b0, lost_q};
      end else if (REG_ADDR == ADDR_TALLY) begin
         rdata_d = tally_q;
      end else if (REG_ADDR == ADDR_ITEM_BYTE) begin
         // Tag byte first, then middle, then least
         if (byte_idx_q == 2'h0) begin
            rdata_d = empty ? {TAG_INVALID, 3'h0} : head_item[23:16];
         end else if (byte_idx_q == 2'h1) begin
            rdata_d = item_q[15:8];
         end else begin
            rdata_d = item_q[7:0];
         end
      end else if (REG_ADDR == ADDR_SEQ_1_2) begin
         rdata_d = seq12_q;
      end else if (REG_ADDR == ADDR_SEQ_3_4) begin
         rdata_d = seq34_q;
      end else if (REG_ADDR == ADDR_SEQ_5_6) begin
         rdata_d = seq56_q;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         REG_RDATA  <= 8'h00;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= rdata_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_tally_up;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (push_ok && !pop) |=> (tally_q == $past(tally_q) + 8'h01);
   endproperty
   a_tally_up: assert property (p_tally_up) else $error("tally did not rise on push");

   property p_tally_down;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (pop && !push_ok) |=> (tally_q == $past(tally_q) - 8'h01);
   endproperty
   a_tally_down: assert property (p_tally_down) else $error("tally did not fall on pop");

   property p_tally_bound;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (tally_q <= DEPTH_COUNT);
   endproperty
   a_tally_bound: assert property (p_tally_bound) else $error("tally above depth");

   property p_pop_burst;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (data_rd && byte_idx_q == 2'h0 && !empty) ##1 (data_rd && !BURST_END) ##1 data_rd
         |-> pop ##1 (readout_pos_q == $past(readout_pos_q) + 7'h01);
   endproperty
   a_pop_burst: assert property (p_pop_burst) else $error("burst did not advance readout");

   property p_lost_sat;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (drop && lost_q == LOST_MAX) |=> (lost_q == LOST_MAX);
   endproperty
   a_lost_sat: assert property (p_lost_sat) else $error("lost tally left saturation");

   property p_lost_clear;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      pop |=> (lost_q == LOST_RST);
   endproperty
   a_lost_clear: assert property (p_lost_clear) else $error("lost tally not cleared on pop");

   property p_invalid;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (data_rd && byte_idx_q == 2'h0 && empty) |=> (REG_RVALID && REG_RDATA[7:3] == TAG_INVALID);
   endproperty
   a_invalid: assert property (p_invalid) else $error("empty read lacks invalid tag");

   property p_msb_first;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (data_rd && byte_idx_q == 2'h0 && !empty) |=> (REG_RDATA == $past(head_item[23:16]));
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first byte is not the tag byte");

   property p_write_inert;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (REG_WR && !REG_RD && REG_ADDR == ADDR_ITEM_BYTE && !push_valid)
         |=> ($stable(tally_q) && $stable(readout_pos_q) && $stable(byte_idx_q));
   endproperty
   a_write_inert: assert property (p_write_inert) else $error("item port write had effect");

   property p_tally_hold;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (push_ok == pop) |=> $stable(tally_q);
   endproperty
   a_tally_hold: assert property (p_tally_hold) else $error("tally moved without net change");

   property p_lost_count;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (drop && lost_q != LOST_MAX) |=> (lost_q == $past(lost_q) + 7'h01);
   endproperty
   a_lost_count: assert property (p_lost_count) else $error("lost tally missed a drop");

   property p_read_wrap;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (pop && readout_pos_q == 7'h7F) |=> (readout_pos_q == POS_RST);
   endproperty
   a_read_wrap: assert property (p_read_wrap) else $error("readout position did not wrap");

   property p_byte_cycle;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (data_rd && byte_idx_q == LAST_BYTE) |=> (byte_idx_q == 2'h0);
   endproperty
   a_byte_cycle: assert property (p_byte_cycle) else $error("byte count past third byte");

   property p_split_keep;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      (BURST_END && !data_rd) |=> (byte_idx_q == 2'h0 && $stable(readout_pos_q));
   endproperty
   a_split_keep: assert property (p_split_keep) else $error("split burst consumed an item");

   property p_no_pop_empty;
      @(posedge CLK_SYS) disable iff (SYS_RST)
      empty |-> !pop;
   endproperty
   a_no_pop_empty: assert property (p_no_pop_empty) else $error("pop from an empty store");

   c_pop: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) pop);
   c_drop: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) drop);
   c_empty_rd: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) data_rd && empty);
   c_wrap: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) pop && readout_pos_q == 7'h7F);
endmodule
`default_nettype wire

// ===== dv/tsfr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsfr_conv_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Request from the sequencer, and the slow answer setting
   input  wire logic        conv_req,
   input  wire logic [2:0]  conv_slot,
   input  wire logic        slow,
   // Answer
   output logic             conv_done,
   output logic      [18:0] ch1,
   output logic      [18:0] ch2
);
   logic [3:0] wait_q;
   // Values invert every cycle between answers so a sample one cycle late never matches
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_done <= 1'b0;
         wait_q    <= 4'h0;
         ch1       <= 19'h00000;
         ch2       <= 19'h7FFFF;
      end else if (!conv_done && conv_req && wait_q >= (slow ? 4'h7 : 4'h0)) begin
         conv_done <= 1'b1;
         ch1       <= {13'h0A5A, 3'h0, conv_slot};
         ch2       <= ~{13'h0A5A, 3'h0, conv_slot};
      end else begin
         conv_done <= 1'b0;
         wait_q    <= (conv_done || !conv_req) ? 4'h0 : wait_q + 4'h1;
         ch1       <= ~ch1;
         ch2       <= ~ch2;
      end
   end
endmodule
`default_nettype wire

// ===== dv/tb_tagged_sample_fifo_readout.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tagged_sample_fifo_readout import tsfr_pkg::*;;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_rd = 1'b0;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        burst_end = 1'b0;
   logic        sample_start = 1'b0;
   logic        slow = 1'b0;
   logic [7:0]  reg_rdata;
   logic        reg_rvalid;
   logic        conv_req;
   logic [2:0]  conv_slot;
   logic [3:0]  conv_code;
   logic        emit_one;
   logic        emit_two;
   logic        conv_done;
   logic [18:0] conv_ch1;
   logic [18:0] conv_ch2;
   logic [2:0]  active_slots;
   logic [7:0]  rd_q;
   logic [23:0] item;
   logic [3:0]  codes [6] = '{4'h1, 4'h4, 4'h9, 4'h0, 4'h1, 4'h0};
   int          n_mismatch = 0;
   int          n_tests = 0;

   always #4 clk = ~clk;

   tsfr_readout DUT (.CLK_SYS(clk), .SYS_RST(rst), .REG_RD(reg_rd), .REG_WR(reg_wr),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .BURST_END(burst_end),
      .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .SAMPLE_START(sample_start),
      .CONV_REQ(conv_req), .CONV_SLOT(conv_slot), .CONV_CODE(conv_code),
      .EMIT_ONE(emit_one), .EMIT_TWO(emit_two), .CONV_DONE(conv_done),
      .CONV_CH1(conv_ch1), .CONV_CH2(conv_ch2), .ACTIVE_SLOTS(active_slots));

   tsfr_conv_model u_conv (.clk(clk), .rst(rst), .conv_req(conv_req), .conv_slot(conv_slot),
      .slow(slow), .conv_done(conv_done), .ch1(conv_ch1), .ch2(conv_ch2));

////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk({23'h0, reg_rvalid}, 24'h1, "rvalid");
      rd_q = reg_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Three back-to-back reads form one burst; each byte lands one edge after its read
   task automatic rd_item;
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= ADDR_ITEM_BYTE;
      for (int b = 2; b >= 0; b--) begin
         @(posedge clk);
         if (b == 0) begin
            reg_rd <= 1'b0;
         end
         #1;
         chk({23'h0, reg_rvalid}, 24'h1, "rvalid");
         item[b*8+:8] = reg_rdata;
      end
   endtask

   // Three slots answer per period; pushes land within three cycles of the last answer
   task automatic run_period;
      int n;
      int t;
      n = 0;
      t = 0;
      @(posedge clk);
      sample_start <= 1'b1;
      @(posedge clk);
      sample_start <= 1'b0;
      while (n < 3 && t < 200) begin
         @(posedge clk);
         #1;
         if (conv_done === 1'b1) n++;
         t++;
      end
      chk({23'h0, t < 200}, 24'h1, "period done");
      repeat (3) @(posedge clk);
   endtask

   function automatic logic [23:0] exp_item(input int i);
      logic [18:0] v;
      v = {13'h0A5A, 3'h0, 3'((i / 2) % 3)};
      return {5'((i / 2) % 3 + 1 + 6 * (i % 2)), (i % 2 == 1) ? ~v : v};
   endfunction

   task automatic finish_test;
      $display("Mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (conv_req === 1'b1) begin
         chk({20'h0, conv_code}, {20'h0, codes[conv_slot]}, "code");
         chk({22'h0, emit_one, emit_two}, {22'h0, codes[conv_slot] == SLOT_EMIT1 ||
             codes[conv_slot] == SLOT_EMIT12, codes[conv_slot] == SLOT_EMIT12}, "emit");
      end
   end

   initial begin
      #200us;
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_TALLY);
      chk(rd_q, TALLY_RST, "tally reset");
      rd(ADDR_LOST);
      chk(rd_q, LOST_RST, "lost reset");
      rd_item();
      chk(item, {TAG_INVALID, 19'h0}, "empty item");
      rd(8'h30);
      chk(rd_q, 8'h00, "unmapped");
      wr(ADDR_ITEM_BYTE, 8'hA5);
      wr(ADDR_TALLY, 8'h33);
      rd(ADDR_TALLY);
      chk(rd_q, 8'h00, "write ignored");
      wr(ADDR_SEQ_1_2, 8'h41);
      wr(ADDR_SEQ_3_4, 8'h09);
      wr(ADDR_SEQ_5_6, 8'h01);
      rd(ADDR_SEQ_1_2);
      chk(rd_q, 8'h41, "seq readback");
      chk(active_slots, 3'h3, "active");
      run_period();
      rd(ADDR_TALLY);
      chk(rd_q, 8'h06, "one period");
      // A split burst must leave the item in place
      rd(ADDR_ITEM_BYTE);
      item = exp_item(0);
      chk(rd_q, item[23:16], "first byte");
      @(posedge clk);
      burst_end <= 1'b1;
      @(posedge clk);
      burst_end <= 1'b0;
      rd(ADDR_TALLY);
      chk(rd_q, 8'h06, "abandoned");
      for (int i = 0; i < 6; i++) begin
         rd_item();
         chk(item, exp_item(i), "item");
         rd(ADDR_TALLY);
         chk(rd_q, 8'(5 - i), "tally pop");
         rd(ADDR_READ_POS);
         chk(rd_q, 8'(i + 1), "position");
      end
      for (int p = 0; p < 44; p++) begin
         @(posedge clk);
         slow <= (p < 2);
         run_period();
      end
      rd(ADDR_LOST);
      chk(rd_q, {1'b0, LOST_MAX}, "lost sat");
      item = (rd_q != 8'h00) ? 24'(DEPTH) : 24'h0;
      rd(ADDR_TALLY);
      chk(item, 24'd128, "available");
      chk(rd_q, DEPTH_COUNT, "full tally");
      for (int i = 0; i < 128; i++) begin
         rd_item();
         chk(item, exp_item(i), "drain");
         rd(ADDR_TALLY);
         chk(rd_q, 8'(127 - i), "drain tally");
         rd(ADDR_LOST);
         chk(rd_q, 8'h00, "lost clear");
      end
      rd(ADDR_READ_POS);
      chk(rd_q, 8'h06, "wrap");
      rd(ADDR_FILL_POS);
      chk(rd_q, 8'h06, "fill position");
      finish_test();
   end
endmodule
`default_nettype wire
